//--- hdl/bst_pkg.sv
// shared constants and types for the boundary-scan test access block
package bst_pkg;
    localparam int IR_LEN = 4;
    localparam logic [IR_LEN-1:0] IR_RESET_VAL = 4'h1;
    localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 4'h1;
    localparam logic [IR_LEN-1:0] OP_BYPASS = 4'hF;
    localparam logic [IR_LEN-1:0] OP_IDCODE = 4'h1;
    localparam int ID_LEN = 32;
    // identity value is arbitrary
    localparam logic [ID_LEN-1:0] ID_VALUE = 32'h0000_1001;
    localparam int SYNC_STAGES = 2;
    // pin levels after reset: tck and tap reset high, the rest low
    localparam logic [6:0] PIN_IDLE_VAL = 7'h09;

    typedef enum logic [15:0] {
        BST_RESET  = 16'h0001,
        BST_IDLE   = 16'h0002,
        BST_SEL_DR = 16'h0004,
        BST_CAP_DR = 16'h0008,
        BST_SH_DR  = 16'h0010,
        BST_EX1_DR = 16'h0020,
        BST_PA_DR  = 16'h0040,
        BST_EX2_DR = 16'h0080,
        BST_UPD_DR = 16'h0100,
        BST_SEL_IR = 16'h0200,
        BST_CAP_IR = 16'h0400,
        BST_SH_IR  = 16'h0800,
        BST_EX1_IR = 16'h1000,
        BST_PA_IR  = 16'h2000,
        BST_EX2_IR = 16'h4000,
        BST_UPD_IR = 16'h8000
    } bst_state_t;
endpackage

//--- hdl/bst_sync_if.sv
// synchronised pin levels passed from the sampler to the tap logic
`timescale 1ns/1ps
interface bst_sync_if;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic std_sel;
    logic scan_en;
    logic bidir_ctl;
    modport src (output tck, tms, tdi, trst_n, std_sel, scan_en, bidir_ctl);
    modport dst (input tck, tms, tdi, trst_n, std_sel, scan_en, bidir_ctl);
endinterface

//--- hdl/bst_pin_sync.sv
// two-stage synchronisers for every tester pin
`timescale 1ns/1ps
module bst_pin_sync
    import bst_pkg::*;
(
    // clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    // raw pins
    input  wire logic [6:0] i_pins,
    // synchronised levels
    bst_sync_if.src    sync
);
    logic [6:0] stage1_reg;
    logic [6:0] stage2_reg;
    logic [6:0] stage1_next;
    logic [6:0] stage2_next;

    always_comb begin
        stage1_next = i_pins;
        stage2_next = stage1_reg;
    end

    // trst_n and tck idle high; others reset low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1_reg <= PIN_IDLE_VAL;
            stage2_reg <= PIN_IDLE_VAL;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign sync.tck       = stage2_reg[0];
    assign sync.tms       = stage2_reg[1];
    assign sync.tdi       = stage2_reg[2];
    assign sync.trst_n    = stage2_reg[3];
    assign sync.std_sel   = stage2_reg[4];
    assign sync.scan_en   = stage2_reg[5];
    assign sync.bidir_ctl = stage2_reg[6];
endmodule

//--- hdl/bst_tap.sv
// boundary-scan tap controller sampling the test clock on the system clock
//
// Notes on behaviour
// - test clock edges move state and data through the scan logic
// - instruction and data bits enter serially on tdi at rising tck
// - instruction and data bits leave serially on tdo
// - tms steers the tap state transitions
// - tap_reset_n low forces the initial state regardless of tck and tms
// - scan_standard_select low selects 1149.1, high selects 1149.6
// - scan shift enable input, held low in normal operation
// - bidir_force_input_ctl forces bidirectional pins to input during shift
`timescale 1ns/1ps
module bst_tap
    import bst_pkg::*;
(
    // clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_nrst,
    // tester pins
    input  wire logic  i_tck,
    input  wire logic  i_tms,
    input  wire logic  i_tdi,
    input  wire logic  i_tap_reset_n,
    // static test pins
    input  wire logic  i_scan_standard_select,
    input  wire logic  i_scan_shift_en,
    input  wire logic  i_bidir_force_input_ctl,
    // serial output
    output logic       o_tdo,
    output logic       o_tdo_oe,
    // core-facing controls
    output logic       o_std_1149_6,
    output logic       o_scan_shift_en,
    output logic       o_bidir_force_input,
    output logic       o_tap_in_reset
);
    logic rst_s1_reg;
    logic rst_n_reg;
    bst_sync_if sync ();

    // reset release through two flops, assert asynchronously
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    bst_pin_sync u_sync (
        .i_clk   (i_clk),
        .i_rst_n (rst_n_reg),
        .i_pins  ({i_bidir_force_input_ctl, i_scan_shift_en,
                   i_scan_standard_select, i_tap_reset_n,
                   i_tdi, i_tms, i_tck}),
        .sync    (sync)
    );

    bst_state_t        state_reg;
    bst_state_t        state_next;
    logic              tck_d_reg;
    logic              tck_d_next;
    logic [IR_LEN-1:0] ir_sh_reg;
    logic [IR_LEN-1:0] ir_sh_next;
    logic [IR_LEN-1:0] ir_reg;
    logic [IR_LEN-1:0] ir_next;
    logic [ID_LEN-1:0] dr_sh_reg;
    logic [ID_LEN-1:0] dr_sh_next;
    logic              tdo_reg;
    logic              tdo_next;
    logic              oe_reg;
    logic              oe_next;
    logic              std_reg;
    logic              scan_reg;
    logic              bidir_reg;
    logic              inrst_reg;
    logic              std_next;
    logic              scan_next;
    logic              bidir_next;
    logic              inrst_next;
    logic              rise;
    logic              fall;
    logic              in_shift;

    // edges found from the synchronised copy, never from the first stage
    assign rise = sync.tck & ~tck_d_reg;
    assign fall = ~sync.tck & tck_d_reg;
    assign in_shift = (state_reg == BST_SH_DR) || (state_reg == BST_SH_IR);

    always_comb begin
        tck_d_next = sync.tck;
        state_next = state_reg;
        ir_sh_next = ir_sh_reg;
        ir_next    = ir_reg;
        dr_sh_next = dr_sh_reg;
        tdo_next   = tdo_reg;
        oe_next    = oe_reg;
        if (!sync.trst_n) begin
            state_next = BST_RESET;
            ir_next    = IR_RESET_VAL;
            oe_next    = 1'b0;
        end else if (rise) begin
            case (state_reg)
                BST_RESET:  state_next = sync.tms ? BST_RESET  : BST_IDLE;
                BST_IDLE:   state_next = sync.tms ? BST_SEL_DR : BST_IDLE;
                BST_SEL_DR: state_next = sync.tms ? BST_SEL_IR : BST_CAP_DR;
                BST_CAP_DR: state_next = sync.tms ? BST_EX1_DR : BST_SH_DR;
                BST_SH_DR:  state_next = sync.tms ? BST_EX1_DR : BST_SH_DR;
                BST_EX1_DR: state_next = sync.tms ? BST_UPD_DR : BST_PA_DR;
                BST_PA_DR:  state_next = sync.tms ? BST_EX2_DR : BST_PA_DR;
                BST_EX2_DR: state_next = sync.tms ? BST_UPD_DR : BST_SH_DR;
                BST_UPD_DR: state_next = sync.tms ? BST_SEL_DR : BST_IDLE;
                BST_SEL_IR: state_next = sync.tms ? BST_RESET  : BST_CAP_IR;
                BST_CAP_IR: state_next = sync.tms ? BST_EX1_IR : BST_SH_IR;
                BST_SH_IR:  state_next = sync.tms ? BST_EX1_IR : BST_SH_IR;
                BST_EX1_IR: state_next = sync.tms ? BST_UPD_IR : BST_PA_IR;
                BST_PA_IR:  state_next = sync.tms ? BST_EX2_IR : BST_PA_IR;
                BST_EX2_IR: state_next = sync.tms ? BST_UPD_IR : BST_SH_IR;
                BST_UPD_IR: state_next = sync.tms ? BST_SEL_DR : BST_IDLE;
                default:    state_next = BST_RESET;
            endcase
            case (state_reg)
                BST_RESET:  ir_next = IR_RESET_VAL;
                BST_CAP_IR: ir_sh_next = IR_CAPTURE_VAL;
                BST_SH_IR:  ir_sh_next = {sync.tdi, ir_sh_reg[IR_LEN-1:1]};
                BST_UPD_IR: ir_next = ir_sh_reg;
                BST_CAP_DR:
                    dr_sh_next = (ir_reg == OP_IDCODE) ? ID_VALUE
                                                       : {ID_LEN{1'b0}};
                BST_SH_DR:
                    // bypass is one bit long, idcode the full word
                    if (ir_reg == OP_IDCODE) begin
                        dr_sh_next = {sync.tdi, dr_sh_reg[ID_LEN-1:1]};
                    end else begin
                        dr_sh_next = {{(ID_LEN-1){1'b0}}, sync.tdi};
                    end
                default: ;
            endcase
        end else if (fall) begin
            // tdo changes only on falling tck, driven in shift states
            oe_next = in_shift;
            if (state_reg == BST_SH_IR) begin
                tdo_next = ir_sh_reg[0];
            end else if (state_reg == BST_SH_DR) begin
                tdo_next = dr_sh_reg[0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= BST_RESET;
            tck_d_reg <= PIN_IDLE_VAL[0];
            ir_sh_reg <= IR_RESET_VAL;
            ir_reg    <= IR_RESET_VAL;
            dr_sh_reg <= {ID_LEN{1'b0}};
            tdo_reg   <= 1'b0;
            oe_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            tck_d_reg <= tck_d_next;
            ir_sh_reg <= ir_sh_next;
            ir_reg    <= ir_next;
            dr_sh_reg <= dr_sh_next;
            tdo_reg   <= tdo_next;
            oe_reg    <= oe_next;
        end
    end

    // static controls, registered so outputs come from flops
    always_comb begin
        std_next   = sync.std_sel;
        scan_next  = sync.scan_en;
        // bidirectionals forced to input only while shifting
        bidir_next = sync.bidir_ctl & sync.scan_en;
        inrst_next = (state_next == BST_RESET);
    end

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            std_reg   <= 1'b0;
            scan_reg  <= 1'b0;
            bidir_reg <= 1'b0;
            inrst_reg <= 1'b1;
        end else begin
            std_reg   <= std_next;
            scan_reg  <= scan_next;
            bidir_reg <= bidir_next;
            inrst_reg <= inrst_next;
        end
    end

    assign o_tdo               = tdo_reg;
    assign o_tdo_oe            = oe_reg;
    assign o_std_1149_6        = std_reg;
    assign o_scan_shift_en     = scan_reg;
    assign o_bidir_force_input = bidir_reg;
    assign o_tap_in_reset      = inrst_reg;

    a_trst_forces_reset: assert property (
        @(posedge i_clk) disable iff (!rst_n_reg)
        !sync.trst_n |=> state_reg == BST_RESET)
        else $error("tap not reset by tap_reset_n");

    a_tms_high_reset: assert property (
        @(posedge i_clk) disable iff (!rst_n_reg)
        (sync.trst_n && rise && sync.tms && state_reg == BST_SEL_IR)
        |=> state_reg == BST_RESET)
        else $error("tms high from select-ir did not reset");

    a_state_hold_no_edge: assert property (
        @(posedge i_clk) disable iff (!rst_n_reg)
        (sync.trst_n && !rise) |=> $stable(state_reg))
        else $error("state moved without rising tck");

    a_tdo_on_fall: assert property (
        @(posedge i_clk) disable iff (!rst_n_reg)
        $changed(tdo_reg) |-> $past(fall))
        else $error("tdo changed outside falling tck");

    a_ir_shift_in: assert property (
        @(posedge i_clk) disable iff (!rst_n_reg)
        (sync.trst_n && rise && state_reg == BST_SH_IR)
        |=> ir_sh_reg[IR_LEN-1] == $past(sync.tdi))
        else $error("tdi not shifted into instruction");

    a_tdo_from_dr: assert property (
        @(posedge i_clk) disable iff (!rst_n_reg)
        (sync.trst_n && fall && state_reg == BST_SH_DR)
        |=> tdo_reg == $past(dr_sh_reg[0]) && oe_reg)
        else $error("tdo not driven from data register");

    a_std_follows_pin: assert property (
        @(posedge i_clk) disable iff (!rst_n_reg)
        1'b1 |=> o_std_1149_6 == $past(sync.std_sel))
        else $error("standard select not followed");

    a_bidir_only_shift: assert property (
        @(posedge i_clk) disable iff (!rst_n_reg)
        (sync.bidir_ctl && sync.scan_en) |=> o_bidir_force_input
        ##0 o_scan_shift_en)
        else $error("bidir force not applied in scan shift");
endmodule

//--- bench/bst_tester.sv
// behavioural boundary-scan tester driving the tap pins
`timescale 1ns/1ps
module bst_tester (
    // clock
    input  wire logic i_clk,
    // tap pins
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_tap_reset_n,
    input  wire logic i_tdo
);
    // tms, tdi and reset idle at their pull-ups; tck parks low off frames
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
        o_tap_reset_n = 1'b1;
    end

    // one 164 ns tck period; tdo taken just before the rise
    task automatic step(input logic tms, input logic tdi,
                        output logic tdo);
        @(posedge i_clk);
        o_tms <= tms;
        o_tdi <= tdi;
        repeat (10) @(posedge i_clk);
        tdo = i_tdo;
        o_tck <= 1'b1;
        repeat (20) @(posedge i_clk);
        o_tck <= 1'b0;
        repeat (10) @(posedge i_clk);
        // released data line floats back to its pull-up
        o_tdi <= 1'b1;
    endtask

    // the device never resets its own tap, so the tester pulses it
    task automatic pulse_reset();
        @(posedge i_clk);
        o_tap_reset_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        o_tap_reset_n <= 1'b1;
        repeat (6) @(posedge i_clk);
    endtask
endmodule

//--- bench/testbench.sv
// self-checking bench for the boundary-scan tap block
`timescale 1ns/1ps
module testbench;
    import bst_pkg::*;
    logic        i_clk;
    logic        i_nrst;
    logic        tck, tms, tdi, trst_n;
    logic        sel, shen, bidir;
    logic        tdo, tdo_oe, std6, shen_o, bidir_o, in_rst;
    logic [31:0] out;
    int          fails;
    int          checked;

    always #2 i_clk = ~i_clk;

    bst_tap bst_tap_inst (
        .i_clk                  (i_clk),
        .i_nrst                 (i_nrst),
        .i_tck                  (tck),
        .i_tms                  (tms),
        .i_tdi                  (tdi),
        .i_tap_reset_n          (trst_n),
        .i_scan_standard_select (sel),
        .i_scan_shift_en        (shen),
        .i_bidir_force_input_ctl(bidir),
        .o_tdo                  (tdo),
        .o_tdo_oe               (tdo_oe),
        .o_std_1149_6           (std6),
        .o_scan_shift_en        (shen_o),
        .o_bidir_force_input    (bidir_o),
        .o_tap_in_reset         (in_rst)
    );

    bst_tester bst_tester_inst (
        .i_clk        (i_clk),
        .o_tck        (tck),
        .o_tms        (tms),
        .o_tdi        (tdi),
        .o_tap_reset_n(trst_n),
        // undriven tdo has no pull, so the tester sees garbage
        .i_tdo        (tdo_oe ? tdo : ~tdo)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // tms pattern, lsb first, tdi held at its idle level
    task automatic walk(input logic [7:0] bits, input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            bst_tester_inst.step(bits[i], 1'b1, d);
        end
    endtask

    // shift n bits lsb first, then update and park in idle
    task automatic scan(input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic d;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            bst_tester_inst.step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        walk(8'h01, 2);
    endtask

    task automatic t_reset_values();
        check({in_rst, tdo_oe, tdo}, 3'h4);
        check({std6, shen_o, bidir_o}, 3'h0);
    endtask

    // ir capture pattern out, bypass loaded, one-bit delay in dr
    task automatic t_ir_bypass();
        walk(8'h1F, 6);
        walk(8'h03, 4);
        check(tdo_oe, 1'b1);
        scan({28'h0, OP_BYPASS}, 4, out);
        check(out[3:0], IR_CAPTURE_VAL);
        walk(8'h01, 3);
        scan(32'hA5, 8, out);
        check(out[7:0], 8'h4A);
    endtask

    // reset in mid-shift with tck still, then identity read
    task automatic t_reset_mid_shift();
        logic d;
        walk(8'h01, 3);
        bst_tester_inst.step(1'b0, 1'b0, d);
        bst_tester_inst.pulse_reset();
        check({in_rst, tdo_oe}, 2'h2);
        walk(8'h00, 1);
        check(in_rst, 1'b0);
        walk(8'h01, 3);
        scan(32'h0, 32, out);
        check(out, ID_VALUE);
    endtask

    // every combination of the static test pins
    task automatic t_static();
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            sel <= i[0];
            shen <= i[1];
            bidir <= i[2];
            repeat (8) @(posedge i_clk);
            check({std6, shen_o, bidir_o},
                  {i[0], i[1], i[1] & i[2]});
        end
        @(posedge i_clk);
        {sel, shen, bidir} <= 3'h0;
    endtask

    // hang guard well above the longest sequence
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        test_done();
    end

    initial begin
        i_clk = 1'b0;
        i_nrst = 1'b0;
        sel = 1'b0;
        shen = 1'b0;
        bidir = 1'b0;
        fails = 0;
        checked = 0;
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (8) @(posedge i_clk);
        t_reset_values();
        t_ir_bypass();
        t_reset_mid_shift();
        t_static();
        test_done();
    end
endmodule
